// ### verilog/clrdec_pkg.sv
package clrdec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int LIT_W = 11;
    localparam int OPC_W = 14;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    localparam int WATCHDOG_W = 16;
    localparam int PRE_W = 8;
    // instruction encodings
    localparam logic [13:0] OPC_WATCHDOG_CLEAR = 14'h0064;
    localparam logic [13:0] OPC_ACC_CLEAR = 14'h0103;
    localparam logic [5:0] OPC_COMPLEMENT_HI = 6'h09;
    localparam logic [5:0] OPC_DECREMENT_HI = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP_HI = 6'h0b;
    localparam logic [6:0] OPC_FILE_CLEAR_HI = 7'h03;
    localparam logic [2:0] OPC_CALL_HI = 3'h4;
    // field positions
    localparam int DEST_BIT = 7;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 4;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE, OP_CLEAR_WATCHDOG, OP_CALL, OP_COMPLEMENT_FILE,
        OP_CLEAR_FILE, OP_CLEAR_ACC, OP_DECREMENT_FILE, OP_DECREMENT_SKIP
    } op_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic we;
    } file_wr_type;

    typedef struct packed {
        logic zero_flag;
        logic timeout_flag;
        logic powerdown_flag;
    } flags_type;
endpackage

// ### verilog/return_stack.sv
`timescale 1ns/1ns
module return_stack
    import clrdec_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int PTR_W = STACK_PTR_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic push,
    input wire logic [PC_W-1:0] push_data,
    output logic [PC_W-1:0] stack_top
);
    // the pointer wraps by itself only when the depth is a power of two
    if (DEPTH != (1 << PTR_W)) begin : g_bad_depth
        $error("stack depth must be 2**PTR_W");
    end

    logic [PC_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] ptr_r;

    // circular: overflow wraps and overwrites the oldest entry
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ptr_r <= '0;
            stack_top <= PC_RESET;
        end else if (clk_en && push) begin
            mem[ptr_r] <= push_data;
            ptr_r <= ptr_r + 1'b1;
            stack_top <= push_data;
        end
    end
endmodule // return_stack

// ### verilog/clear_call_decrement.sv
`timescale 1ns/1ns
// Functional notes
// - clear_watchdog_op zeroes the watchdog_counter
// - clear_watchdog_op zeroes the watchdog prescaler too
// - clear_watchdog_op sets timeout_flag and powerdown_flag only
// - call pushes pc plus one onto stack_top
// - call loads 11-bit literal into pc bits 10..0
// - call takes pc bits 12..11 from pc_high_latch 4..3; no flags
// - call takes two instruction cycles
// - destination bit 0 writes accumulator, 1 writes the register
// - complement_file_op inverts register, updates only zero flag
// - clear_file_op writes zero and sets zero flag
// - clear_accumulator_op writes zero to accumulator, sets zero flag
// - decrement_file_op subtracts one, updates only zero flag
// - decrement_skip_zero_op subtracts one, changes no flags
// - zero result discards next instruction, runs a nop instead
module clear_call_decrement
    import clrdec_pkg::*;
#(
    parameter int WATCHDOG_WIDTH = WATCHDOG_W,
    parameter int PRE_WIDTH = PRE_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [OPC_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic [DATA_W-1:0] file_rd_data,
    input wire logic [DATA_W-1:0] pc_high_latch,
    input wire logic watchdog_tick,
    input wire logic pre_tick,
    output logic [ADDR_W-1:0] file_rd_addr,
    output file_wr_type file_wr,
    output logic [DATA_W-1:0] accumulator,
    output flags_type flags,
    output logic [PC_W-1:0] pc,
    output logic [PC_W-1:0] stack_top,
    output logic [WATCHDOG_WIDTH-1:0] watchdog_counter,
    output logic [PRE_WIDTH-1:0] prescaler,
    output logic busy,
    output op_type last_op
);
    // a counter needs at least one bit to count a tick
    if (WATCHDOG_WIDTH < 1) begin : g_bad_watchdog
        $error("watchdog counter width must be at least one");
    end
    if (PRE_WIDTH < 1) begin : g_bad_prescaler
        $error("prescaler width must be at least one");
    end
    // the call target is the literal plus two latch bits
    if (PC_W != LIT_W + 2) begin : g_bad_pc
        $error("program counter must be two bits wider than the literal");
    end
    if (LATCH_HI - LATCH_LO != 1) begin : g_bad_latch
        $error("two latch bits feed the top of the program counter");
    end
    if (ADDR_W > DEST_BIT) begin : g_bad_dest
        $error("register address must sit below the destination bit");
    end
    // the decoder reads fixed opcode bits and byte-wide constants
    if (OPC_W != 14) begin : g_bad_opcode
        $error("instruction word must be fourteen bits");
    end
    if (DATA_W != 8) begin : g_bad_data
        $error("data path must be eight bits");
    end
    if (LIT_W > OPC_W - 3) begin : g_bad_literal
        $error("call literal must fit below the call opcode");
    end

    typedef enum logic [1:0] {ST_EXEC, ST_FLUSH} phase_type;

    typedef struct packed {
        phase_type phase;
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] acc;
        flags_type flags;
        file_wr_type wr;
        logic [WATCHDOG_WIDTH-1:0] watch_cnt;
        logic [PRE_WIDTH-1:0] pre;
        op_type op;
        logic [1:0] watch_sync;
        logic [1:0] pre_sync;
    } state_type;

    state_type s_r;
    state_type s_nxt;
    logic push;
    logic [PC_W-1:0] push_data;
    op_type op;
    logic [DATA_W-1:0] dec_val;
    logic [DATA_W-1:0] inv_val;
    logic dec_zero;
    logic inv_zero;
    logic to_file;
    logic watch_tick_s;
    logic pre_tick_s;

    function automatic op_type decode(input logic [OPC_W-1:0] w);
        if (w == OPC_WATCHDOG_CLEAR) begin
            return OP_CLEAR_WATCHDOG;
        end
        if (w == OPC_ACC_CLEAR) begin
            return OP_CLEAR_ACC;
        end
        if (w[13:11] == OPC_CALL_HI) begin
            return OP_CALL;
        end
        if (w[13:7] == OPC_FILE_CLEAR_HI) begin
            return OP_CLEAR_FILE;
        end
        if (w[13:8] == OPC_COMPLEMENT_HI) begin
            return OP_COMPLEMENT_FILE;
        end
        if (w[13:8] == OPC_DECREMENT_HI) begin
            return OP_DECREMENT_FILE;
        end
        if (w[13:8] == OPC_DEC_SKIP_HI) begin
            return OP_DECREMENT_SKIP;
        end
        return OP_NONE;
    endfunction

    // wraps at the top of program memory, as the stack push does
    function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] p);
        return p + 13'h0001;
    endfunction

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return (v == ZERO_BYTE);
    endfunction

    function automatic logic [PC_W-1:0] call_target(
        input logic [DATA_W-1:0] latch,
        input logic [OPC_W-1:0] w
    );
        return {latch[LATCH_HI:LATCH_LO], w[LIT_W-1:0]};
    endfunction

    // the two-cycle members of the group; a nop slot follows them
    function automatic logic takes_two(input op_type o, input logic z);
        case (o)
            OP_CALL: return 1'b1;
            OP_DECREMENT_SKIP: return z;
            default: return 1'b0;
        endcase
    endfunction

    // routes a register-operand result by the destination bit
    function automatic state_type put_result(
        input state_type s,
        input logic dest,
        input logic [DATA_W-1:0] v
    );
        state_type r;
        r = s;
        if (dest) begin
            r.wr.we = 1'b1;
            r.wr.data = v;
        end else begin
            r.acc = v;
        end
        return r;
    endfunction

    assign op = decode(instr);
    assign dec_val = file_rd_data - 8'h01;
    assign inv_val = ~file_rd_data;
    assign dec_zero = is_zero(dec_val);
    assign inv_zero = is_zero(inv_val);
    assign to_file = instr[DEST_BIT];
    assign file_rd_addr = instr[ADDR_W-1:0];
    // only the second flop of each synchroniser is read
    assign watch_tick_s = s_r.watch_sync[1];
    assign pre_tick_s = s_r.pre_sync[1];

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr.we = 1'b0;
        push = 1'b0;
        push_data = next_pc(s_r.pc);

        // the ticks come from the watchdog oscillator, not this clock
        s_nxt.watch_sync = {s_r.watch_sync[0], watchdog_tick};
        s_nxt.pre_sync = {s_r.pre_sync[0], pre_tick};

        // free-running counters; the clear below wins over a tick
        if (watch_tick_s) begin
            s_nxt.watch_cnt = s_r.watch_cnt + 1'b1;
        end
        if (pre_tick_s) begin
            s_nxt.pre = s_r.pre + 1'b1;
        end

        case (s_r.phase)
            ST_FLUSH: begin
                // fetched word is dropped; this cycle acts as a nop
                // and the pc holds, so a call's target is fetched next
                s_nxt.phase = ST_EXEC;
                s_nxt.op = OP_NONE;
            end
            ST_EXEC: begin
                if (instr_valid) begin
                    // an unknown opcode still advances the pc
                    s_nxt.op = op;
                    s_nxt.pc = next_pc(s_r.pc);
                    s_nxt.wr.addr = instr[ADDR_W-1:0];
                    case (op)
                        OP_CLEAR_WATCHDOG: begin
                            // the zero flag stays; only two flags move
                            s_nxt.watch_cnt = '0;
                            s_nxt.pre = '0;
                            s_nxt.flags.timeout_flag = 1'b1;
                            s_nxt.flags.powerdown_flag = 1'b1;
                        end

                        OP_CALL: begin
                            push = 1'b1;
                            s_nxt.pc = call_target(pc_high_latch, instr);
                        end

                        OP_COMPLEMENT_FILE: begin
                            s_nxt = put_result(s_nxt, to_file, inv_val);
                            s_nxt.flags.zero_flag = inv_zero;
                        end

                        OP_CLEAR_FILE: begin
                            s_nxt.wr.we = 1'b1;
                            s_nxt.wr.data = ZERO_BYTE;
                            s_nxt.flags.zero_flag = 1'b1;
                        end

                        OP_CLEAR_ACC: begin
                            s_nxt.acc = ZERO_BYTE;
                            s_nxt.flags.zero_flag = 1'b1;
                        end

                        OP_DECREMENT_FILE: begin
                            s_nxt = put_result(s_nxt, to_file, dec_val);
                            s_nxt.flags.zero_flag = dec_zero;
                        end

                        OP_DECREMENT_SKIP: begin
                            // no flag is touched here
                            s_nxt = put_result(s_nxt, to_file, dec_val);
                        end

                        default: begin
                            // other opcodes are handled elsewhere in the core
                        end
                    endcase
                    if (takes_two(op, dec_zero)) begin
                        s_nxt.phase = ST_FLUSH;
                    end
                end
            end
            default: begin
                s_nxt.phase = ST_EXEC;
            end
        endcase
    end

    // one register for all state; clk_en low freezes every field
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_r.phase <= ST_EXEC;
            s_r.pc <= PC_RESET;
            s_r.acc <= ZERO_BYTE;
            s_r.flags <= '0;
            s_r.wr <= '0;
            s_r.watch_cnt <= '0;
            s_r.pre <= '0;
            s_r.op <= OP_NONE;
            s_r.watch_sync <= '0;
            s_r.pre_sync <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // overflow of the return stack wraps and loses the oldest entry
    return_stack #(
        .DEPTH(STACK_DEPTH),
        .PTR_W(STACK_PTR_W)
    ) u_stack (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .push(push),
        .push_data(push_data),
        .stack_top(stack_top)
    );

    assign file_wr = s_r.wr;
    assign accumulator = s_r.acc;
    assign flags = s_r.flags;
    assign pc = s_r.pc;
    assign watchdog_counter = s_r.watch_cnt;
    assign prescaler = s_r.pre;
    // high during the nop slot: the word presented now is ignored
    assign busy = (s_r.phase == ST_FLUSH);
    assign last_op = s_r.op;
endmodule // clear_call_decrement

// ### verif/ccd_monitor.sv
`timescale 1ns/1ns
module ccd_monitor
    import clrdec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [OPC_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic [DATA_W-1:0] file_rd_data,
    input wire logic [DATA_W-1:0] pc_high_latch,
    input wire file_wr_type file_wr,
    input wire flags_type flags,
    input wire logic [PC_W-1:0] pc,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic [WATCHDOG_W-1:0] watchdog_counter,
    input wire logic [PRE_W-1:0] prescaler,
    input wire logic busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic t;
    logic call;
    logic [PC_W-1:0] tgt_r;
    assign t = clk_en && instr_valid && !busy;
    assign call = t && instr[13:11] == 3'h4;
    // target kept here because a slice of a past value cannot be taken
    always_ff @(posedge sys_clk) begin
        tgt_r <= {pc_high_latch[4:3], instr[10:0]};
    end
    property p_watchdog;
        t && instr == 14'h0064 |=> watchdog_counter == 16'h0000
            && prescaler == 8'h00;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog clear missed");
    property p_sts;
        t && instr == 14'h0064 |=> flags.timeout_flag && flags.powerdown_flag
            && flags.zero_flag == $past(flags.zero_flag);
    endproperty
    a_sts: assert property (p_sts)
        else $error("status after watchdog clear wrong");
    property p_push;
        call |=> stack_top == $past(pc) + 13'h0001;
    endproperty
    a_push: assert property (p_push)
        else $error("return address wrong");
    property p_tgt;
        call |=> pc == tgt_r && flags == $past(flags);
    endproperty
    a_tgt: assert property (p_tgt)
        else $error("call target wrong");
    property p_two;
        call |=> busy ##1 !busy;
    endproperty
    a_two: assert property (p_two)
        else $error("call length wrong");
    property p_complement_file_op;
        t && instr[13:7] == 7'h13 |=> file_wr.we
            && file_wr.data == ~$past(file_rd_data);
    endproperty
    a_complement_file_op: assert property (p_complement_file_op)
        else $error("complement write wrong");
    property p_clr;
        t && instr[13:7] == 7'h03 |=> file_wr.we && file_wr.data == 8'h00
            && flags.zero_flag;
    endproperty
    a_clr: assert property (p_clr)
        else $error("register clear wrong");
    property p_skip;
        t && instr[13:8] == 6'h0b && file_rd_data == 8'h01
            |=> busy && flags == $past(flags);
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip wrong");
endmodule // ccd_monitor

bind clear_call_decrement ccd_monitor u_mon (.*);

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    import clrdec_pkg::*;
    logic sys_clk, rst_n, clk_en, instr_valid, watchdog_tick, pre_tick, busy;
    logic [OPC_W-1:0] instr;
    logic [DATA_W-1:0] file_rd_data, pc_high_latch, accumulator;
    logic [ADDR_W-1:0] file_rd_addr;
    logic [PC_W-1:0] pc, stack_top;
    logic [WATCHDOG_W-1:0] watchdog_counter;
    logic [PRE_W-1:0] prescaler;
    file_wr_type file_wr;
    flags_type flags;
    op_type last_op;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    clear_call_decrement u_dut (.*);
    task automatic chk(input string nm, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // b=1 keeps a clear-accumulator valid in the slot that must be dropped
    task automatic exec(input logic [13:0] op, input logic [7:0] rd,
                        input logic b);
        @(posedge sys_clk);
        instr <= op;
        file_rd_data <= rd;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr <= 14'h0103;
        instr_valid <= b;
        #1;
        chk("busy", b, busy);
    endtask
    task automatic slot;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 500) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        instr = 14'h0000;
        instr_valid = 1'b0;
        file_rd_data = 8'h00;
        pc_high_latch = 8'h18;
        watchdog_tick = 1'b1;
        pre_tick = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        exec(14'h0064, 8'h00, 1'b0);
        chk("watchdog", 16'h0000, watchdog_counter);
        chk("op", OP_CLEAR_WATCHDOG, last_op);
        chk("rdaddr", 16'h0003, file_rd_addr);
        chk("pre", 16'h0000, prescaler);
        chk("flags", 3'b011, flags);
        exec(14'h0103, 8'h00, 1'b0);
        chk("acc", 8'h00, accumulator);
        chk("flags", 3'b111, flags);
        exec(14'h09ff, 8'h5a, 1'b0);
        chk("wr", {7'h7f, 8'ha5, 1'b1}, file_wr);
        chk("flags", 3'b011, flags);
        exec(14'h0900, 8'hff, 1'b0);
        chk("acc", 8'h00, accumulator);
        chk("we", 1'b0, file_wr.we);
        chk("flags", 3'b111, flags);
        exec(14'h0300, 8'h00, 1'b0);
        chk("acc", 8'hff, accumulator);
        chk("flags", 3'b011, flags);
        exec(14'h0190, 8'h33, 1'b0);
        chk("wr", {7'h10, 8'h00, 1'b1}, file_wr);
        chk("flags", 3'b111, flags);
        exec(14'h0385, 8'h80, 1'b0);
        chk("wr", {7'h05, 8'h7f, 1'b1}, file_wr);
        chk("acc", 8'hff, accumulator);
        chk("flags", 3'b011, flags);
        exec(14'h0b00, 8'h02, 1'b0);
        chk("acc", 8'h01, accumulator);
        chk("flags", 3'b011, flags);
        exec(14'h0b80, 8'h01, 1'b1);
        chk("wr", {7'h00, 8'h00, 1'b1}, file_wr);
        chk("flags", 3'b011, flags);
        slot();
        chk("acc", 8'h01, accumulator);
        chk("op", OP_NONE, last_op);
        clk_en <= 1'b0;
        exec(14'h0103, 8'h00, 1'b0);
        chk("frozen acc", 8'h01, accumulator);
        chk("frozen flags", 3'b011, flags);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        exec(14'h27ff, 8'h00, 1'b1);
        chk("pc", 13'h1fff, pc);
        chk("top", 13'h0001, stack_top);
        slot();
        chk("flags", 3'b000, flags);
        chk("busy", 1'b0, busy);
        pc_high_latch <= 8'he7;
        exec(14'h2000, 8'h00, 1'b1);
        chk("pc", 13'h0000, pc);
        chk("top", 13'h0000, stack_top);
        slot();
        give_verdict();
    end
endmodule // testbench
